// ===== logic/dbgtb_pkg.sv
// shared constants, register layouts and carrier types of the debug trigger block
`default_nettype none
package dbgtb_pkg;

    // register bus geometry
    localparam int ADR_W  = 8;
    localparam int DAT_W  = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CMPA     = 8'h00;
    localparam logic [7:0] OFS_CMPB     = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_TRIG     = 8'h0c;
    localparam logic [7:0] OFS_STAT     = 8'h10;
    localparam logic [7:0] OFS_FIFO     = 8'h14;
    localparam logic [7:0] OFS_IRQ_STS  = 8'h18;
    localparam logic [7:0] OFS_IRQ_MSK  = 8'h1c;

    // values after reset
    localparam logic [15:0] CMP_RST     = 16'h0000;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  TRIG_RST    = 8'h00;

    // trace storage
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [3:0]  FIFO_FULL   = 4'h8;
    localparam logic [3:0]  FIFO_LAST   = 4'h7;

    // opcode tracking queue, one tracker per comparator plus one for break tags
    localparam logic [2:0]  QUEUE_DEPTH = 3'h4;
    localparam int          TRK_NUM     = 3;
    localparam int          TRK_A       = 0;
    localparam int          TRK_B       = 1;
    localparam int          TRK_BRK     = 2;

    // trigger modes
    localparam logic [3:0] MODE_A_ONLY    = 4'h0;
    localparam logic [3:0] MODE_A_OR_B    = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B  = 4'h2;
    localparam logic [3:0] MODE_B_EVENT   = 4'h3;
    localparam logic [3:0] MODE_A_B_EVENT = 4'h4;
    localparam logic [3:0] MODE_A_DATA    = 4'h5;
    localparam logic [3:0] MODE_A_NOT_DAT = 4'h6;
    localparam logic [3:0] MODE_INSIDE    = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE   = 4'h8;

    // interrupt status bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_RUN_END = 0;
    localparam int IRQ_TRIG    = 1;
    localparam int IRQ_FULL    = 2;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_PRE,
        RUN_POST
    } dbgtb_run_e;

    typedef struct packed {
        logic debug_enable_bit;
        logic arm;
        logic tag_select;
        logic break_request_enable;
        logic rw_match_value_a;
        logic rw_qualify_enable_a;
        logic rw_match_value_b;
        logic rw_qualify_enable_b;
    } dbgtb_ctrl_s;

    typedef struct packed {
        logic       trigger_select_tag;
        logic       begin_select;
        logic [1:0] rsvd;
        logic [3:0] trigger_mode_field;
    } dbgtb_trig_s;

    typedef struct packed {
        logic       armed_flag;
        logic       comparator_a_match_flag;
        logic       comparator_b_match_flag;
        logic       rsvd;
        logic [3:0] fifo_count_field;
    } dbgtb_stat_s;

    // cpu bus and instruction queue view; rw high means read
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        valid;
        logic        rw;
        logic        fetch;
        logic        exec;
        logic        flush;
        logic        cof;
        logic [15:0] cof_addr;
    } dbgtb_cpu_s;

endpackage
`default_nettype wire

// ===== logic/dbgtb_tracker.sv
// opcode tracking queue: follows one tag bit per fetched opcode until it executes
`default_nettype none
module dbgtb_tracker
    import dbgtb_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // queue events
    input  wire logic push_i,
    input  wire logic tag_i,
    input  wire logic pop_i,
    input  wire logic flush_i,
    // tagged opcode executed
    output logic      hit_o
);

    logic [QUEUE_DEPTH-1:0] tags_ff;
    logic [2:0]             level_ff;
    logic [QUEUE_DEPTH-1:0] nxt_tags;
    logic [2:0]             nxt_level;

    // head of queue leaves on execute; its tag says whether the compare really ran
    assign hit_o = pop_i && (level_ff != 3'h0) && tags_ff[0];

    always_comb begin
        nxt_tags  = tags_ff;
        nxt_level = level_ff;
        if (pop_i && (level_ff != 3'h0)) begin
            nxt_tags  = tags_ff >> 1;
            nxt_level = level_ff - 3'h1;
        end
        // overflow drops the fetch; the cpu never holds more than the queue depth
        if (push_i && (nxt_level < QUEUE_DEPTH)) begin
            nxt_tags[nxt_level[1:0]] = tag_i;
            nxt_level                = nxt_level + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            tags_ff  <= '0;
            level_ff <= 3'h0;
        end else begin
            tags_ff  <= nxt_tags;
            level_ff <= nxt_level;
        end
    end

    AST_TRK_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i)
        flush_i |=> (level_ff == 3'h0) && !hit_o)
        else $error("tracker queue not empty after flush");

endmodule
`default_nettype wire

// ===== logic/dbgtb_top.sv
// debug trigger, trace capture and breakpoint control with a wishbone register slave
`default_nettype none
// Overview of operation
// - force breakpoint waits for the executing instruction to finish, then enters background
// - tag breakpoint marks fetched opcode; execution of it enters background instead
// - outside the range modes, tag triggers count a comparator match only if the compared opcode executes
// - each comparator owns a separate opcode tracking queue
// - four-bit mode field selects one of nine trigger modes
// - begin select: capture after trigger, or circular capture until trigger
// - arming sets armed flag, clears both match flags and fifo count
// - begin run ends on full fifo, end run ends on trigger
// - writing zero to arm or debug enable stops the run at once
// - fifo stores change-of-flow addresses, or data low byte in event modes
// - event-only modes ignore begin select and always trace begin type
// - optional read/write qualification of each comparator match
// - qualified match requests breakpoint only with break enable; tag select picks type
module dbgtb_top
    import dbgtb_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    output logic      [DAT_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    // cpu bus and instruction queue
    input  wire dbgtb_cpu_s       cpu_i,
    // breakpoint requests
    output logic                  brk_tag_o,
    output logic                  brk_force_o,
    output logic                  background_entry_o,
    // interrupt
    output logic                  irq_o
);

    dbgtb_ctrl_s        debug_control_reg_ff;
    dbgtb_trig_s        trigger_control_reg_ff;
    logic [15:0]        cmpa_ff;
    logic [15:0]        cmpb_ff;
    dbgtb_run_e         state_ff;
    dbgtb_run_e         nxt_state;
    logic               a_flag_ff;
    logic               b_flag_ff;
    logic [15:0]        fifo_mem [FIFO_DEPTH];
    logic [2:0]         wr_ptr_ff;
    logic [2:0]         rd_ptr_ff;
    logic [3:0]         fifo_count_ff;
    logic [IRQ_W-1:0]   irq_sts_ff;
    logic [IRQ_W-1:0]   irq_msk_ff;
    logic [IRQ_W-1:0]   irq_evt;
    logic               irq_ff;
    logic               ack_ff;
    logic [DAT_W-1:0]   dat_ff;
    logic [DAT_W-1:0]   rdata;
    logic               force_pend_ff;
    logic               brk_tag_ff;
    logic               brk_force_ff;
    logic               bg_entry_ff;

    function automatic logic adr_is(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction

    function automatic logic is_event_only(input logic [3:0] mode);
        return (mode == MODE_B_EVENT) || (mode == MODE_A_B_EVENT);
    endfunction

    // ---------------- bus decode ----------------
    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_ctrl;
    logic        wr_trig;
    logic        arm_start;
    logic        stop;
    dbgtb_ctrl_s nxt_ctrl;

    assign req       = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr        = req && wb_we_i;
    assign rd        = req && !wb_we_i;
    assign nxt_ctrl  = dbgtb_ctrl_s'(wb_dat_i[7:0]);
    assign wr_ctrl   = wr && adr_is(wb_adr_i, OFS_CTRL) && wb_sel_i[0];
    assign wr_trig   = wr && adr_is(wb_adr_i, OFS_TRIG) && wb_sel_i[0];
    assign arm_start = wr_ctrl && nxt_ctrl.arm && nxt_ctrl.debug_enable_bit;
    assign stop      = wr_ctrl && !(nxt_ctrl.arm && nxt_ctrl.debug_enable_bit);

    // ---------------- comparators ----------------
    logic               armed;
    logic               qa;
    logic               qb;
    logic               brk_q;
    logic               brk_tag_req;
    logic [TRK_NUM-1:0] trk_tag;
    logic [TRK_NUM-1:0] trk_hit;
    logic               ev_a;
    logic               ev_b;
    logic               data_eq;
    logic               in_range;
    logic               ev_only;
    logic               begin_type;
    logic               trig_raw;
    logic               trig_hit;

    assign armed = state_ff != RUN_IDLE;
    assign qa = cpu_i.valid && (cpu_i.addr == cmpa_ff) &&
                (!debug_control_reg_ff.rw_qualify_enable_a ||
                 (cpu_i.rw == debug_control_reg_ff.rw_match_value_a));
    assign qb = cpu_i.valid && (cpu_i.addr == cmpb_ff) &&
                (!debug_control_reg_ff.rw_qualify_enable_b ||
                 (cpu_i.rw == debug_control_reg_ff.rw_match_value_b));

    assign brk_q       = armed && debug_control_reg_ff.break_request_enable && (qa || qb);
    assign brk_tag_req = brk_q && debug_control_reg_ff.tag_select && cpu_i.fetch;
    assign trk_tag     = {brk_tag_req, qb, qa};

    // trackers only see fetches; a queue flush forgets every pending tag
    for (genvar g = 0; g < TRK_NUM; g++) begin : g_trk
        dbgtb_tracker u_trk (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .push_i  (cpu_i.fetch && cpu_i.valid),
            .tag_i   (trk_tag[g]),
            .pop_i   (cpu_i.exec),
            .flush_i (cpu_i.flush),
            .hit_o   (trk_hit[g])
        );
    end

    assign ev_a = trigger_control_reg_ff.trigger_select_tag ? trk_hit[TRK_A] : qa;
    assign ev_b = trigger_control_reg_ff.trigger_select_tag ? trk_hit[TRK_B] : qb;
    assign data_eq  = cpu_i.data == cmpb_ff[7:0];
    assign in_range = cpu_i.valid && (cpu_i.addr >= cmpa_ff) && (cpu_i.addr <= cmpb_ff);
    assign ev_only  = is_event_only(trigger_control_reg_ff.trigger_mode_field);
    assign begin_type = ev_only || trigger_control_reg_ff.begin_select;

    always_comb begin
        unique case (trigger_control_reg_ff.trigger_mode_field)
            MODE_A_ONLY:    trig_raw = ev_a;
            MODE_A_OR_B:    trig_raw = ev_a || ev_b;
            MODE_A_THEN_B:  trig_raw = a_flag_ff && ev_b;
            MODE_B_EVENT:   trig_raw = ev_b;
            MODE_A_B_EVENT: trig_raw = a_flag_ff && ev_b;
            MODE_A_DATA:    trig_raw = ev_a && data_eq;
            MODE_A_NOT_DAT: trig_raw = ev_a && !data_eq;
            MODE_INSIDE:    trig_raw = in_range;
            MODE_OUTSIDE:   trig_raw = cpu_i.valid && !in_range;
            default:        trig_raw = 1'b0;
        endcase
    end
    assign trig_hit = armed && trig_raw;

    // ---------------- trace fifo ----------------
    logic        push;
    logic [15:0] push_data;
    logic        fifo_full;
    logic        pop;

    // event modes push on every qualifying b event; others on each change of flow
    assign push = armed && (ev_only ? trig_raw : cpu_i.cof) &&
                  (!begin_type || (state_ff == RUN_POST) || trig_hit);
    assign push_data = ev_only ? {8'h00, cpu_i.data} : cpu_i.cof_addr;
    assign fifo_full = fifo_count_ff == FIFO_FULL;
    // reads drain only between runs, so a pop never races a push
    assign pop = rd && adr_is(wb_adr_i, OFS_FIFO) && !armed && (fifo_count_ff != 4'h0);

    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_mem[wr_ptr_ff] <= push_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || arm_start) begin
            wr_ptr_ff     <= 3'h0;
            rd_ptr_ff     <= 3'h0;
            fifo_count_ff <= 4'h0;
        end else if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 3'h1;
            // circular end-trace capture overwrites the oldest entry
            if (fifo_full) begin
                rd_ptr_ff <= rd_ptr_ff + 3'h1;
            end else begin
                fifo_count_ff <= fifo_count_ff + 4'h1;
            end
        end else if (pop) begin
            rd_ptr_ff     <= rd_ptr_ff + 3'h1;
            fifo_count_ff <= fifo_count_ff - 4'h1;
        end
    end

    // ---------------- run control ----------------
    always_comb begin
        nxt_state = state_ff;
        if (arm_start) begin
            nxt_state = RUN_PRE;
        end else if (stop) begin
            nxt_state = RUN_IDLE;
        end else begin
            unique case (state_ff)
                RUN_IDLE: nxt_state = RUN_IDLE;
                RUN_PRE: begin
                    if (trig_hit) begin
                        nxt_state = begin_type ? RUN_POST : RUN_IDLE;
                    end
                end
                RUN_POST: begin
                    if (push && (fifo_count_ff == FIFO_LAST)) begin
                        nxt_state = RUN_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= RUN_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || arm_start) begin
            a_flag_ff <= 1'b0;
            b_flag_ff <= 1'b0;
        end else begin
            a_flag_ff <= a_flag_ff || (armed && ev_a);
            b_flag_ff <= b_flag_ff || (armed && ev_b);
        end
    end

    // ---------------- breakpoints ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_pend_ff <= 1'b0;
            brk_force_ff  <= 1'b0;
            brk_tag_ff    <= 1'b0;
            bg_entry_ff   <= 1'b0;
        end else begin
            // a new request in the issue cycle stays pending for the next boundary
            force_pend_ff <= (force_pend_ff && !cpu_i.exec) ||
                             (brk_q && !debug_control_reg_ff.tag_select);
            brk_force_ff  <= force_pend_ff && cpu_i.exec;
            brk_tag_ff    <= brk_tag_req;
            bg_entry_ff   <= trk_hit[TRK_BRK];
        end
    end

    // ---------------- registers ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmpa_ff <= CMP_RST;
            cmpb_ff <= CMP_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr && adr_is(wb_adr_i, OFS_CMPA) && wb_sel_i[i]) begin
                    cmpa_ff[i*8+:8] <= wb_dat_i[i*8+:8];
                end
                if (wr && adr_is(wb_adr_i, OFS_CMPB) && wb_sel_i[i]) begin
                    cmpb_ff[i*8+:8] <= wb_dat_i[i*8+:8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_control_reg_ff   <= dbgtb_ctrl_s'(CTRL_RST);
            trigger_control_reg_ff <= dbgtb_trig_s'(TRIG_RST);
        end else begin
            if (wr_ctrl) begin
                debug_control_reg_ff <= nxt_ctrl;
            end
            if (wr_trig) begin
                trigger_control_reg_ff <= dbgtb_trig_s'({wb_dat_i[7:6], 2'h0, wb_dat_i[3:0]});
            end
        end
    end

    assign irq_evt[IRQ_RUN_END] = armed && (nxt_state == RUN_IDLE);
    assign irq_evt[IRQ_TRIG]    = trig_hit;
    assign irq_evt[IRQ_FULL]    = push && (fifo_count_ff == FIFO_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts_ff <= '0;
            irq_msk_ff <= '0;
            irq_ff     <= 1'b0;
        end else begin
            // set beats a simultaneous write-one-to-clear
            if (wr && adr_is(wb_adr_i, OFS_IRQ_STS) && wb_sel_i[0]) begin
                irq_sts_ff <= (irq_sts_ff & ~wb_dat_i[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_sts_ff <= irq_sts_ff | irq_evt;
            end
            if (wr && adr_is(wb_adr_i, OFS_IRQ_MSK) && wb_sel_i[0]) begin
                irq_msk_ff <= wb_dat_i[IRQ_W-1:0];
            end
            irq_ff <= |(irq_sts_ff & irq_msk_ff);
        end
    end

    always_comb begin
        dbgtb_ctrl_s ctrl_rd;
        dbgtb_stat_s stat_rd;
        ctrl_rd     = debug_control_reg_ff;
        ctrl_rd.arm = armed;
        stat_rd     = '{armed_flag: armed, comparator_a_match_flag: a_flag_ff,
                        comparator_b_match_flag: b_flag_ff, rsvd: 1'b0,
                        fifo_count_field: fifo_count_ff};
        unique case (wb_adr_i)
            OFS_CMPA:    rdata = {16'h0000, cmpa_ff};
            OFS_CMPB:    rdata = {16'h0000, cmpb_ff};
            OFS_CTRL:    rdata = {24'h000000, ctrl_rd};
            OFS_TRIG:    rdata = {24'h000000, trigger_control_reg_ff};
            OFS_STAT:    rdata = {24'h000000, stat_rd};
            OFS_FIFO:    rdata = (fifo_count_ff != 4'h0) ? {16'h0000, fifo_mem[rd_ptr_ff]} : 32'h0;
            OFS_IRQ_STS: rdata = {29'h0, irq_sts_ff};
            OFS_IRQ_MSK: rdata = {29'h0, irq_msk_ff};
            default:     rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= req;
            dat_ff <= rd ? rdata : 32'h0;
        end
    end

    assign wb_ack_o           = ack_ff;
    assign wb_dat_o           = dat_ff;
    assign brk_tag_o          = brk_tag_ff;
    assign brk_force_o        = brk_force_ff;
    assign background_entry_o = bg_entry_ff;
    assign irq_o              = irq_ff;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_FORCE_AT_BOUNDARY: assert property (brk_force_o |-> $past(cpu_i.exec) && $past(force_pend_ff))
        else $error("force break issued off an instruction boundary");
    AST_BG_ON_TAG_EXEC: assert property (background_entry_o |-> $past(cpu_i.exec))
        else $error("background entry without tagged opcode execution");
    AST_TAG_TRIG_TRACKED: assert property ((state_ff == RUN_PRE) && trigger_control_reg_ff.trigger_select_tag &&
        (((trigger_control_reg_ff.trigger_mode_field == MODE_A_ONLY) && !trk_hit[TRK_A]) ||
         ((trigger_control_reg_ff.trigger_mode_field == MODE_B_EVENT) && !trk_hit[TRK_B])) && !wr_ctrl
        |=> state_ff == RUN_PRE)
        else $error("tag trigger fired without executed opcode");
    AST_BAD_MODE_IDLE: assert property ((state_ff == RUN_PRE) &&
        (trigger_control_reg_ff.trigger_mode_field > MODE_OUTSIDE) && !wr_ctrl |=> state_ff == RUN_PRE)
        else $error("undefined trigger mode produced a trigger");
    AST_END_TYPE_STOP: assert property ((state_ff == RUN_PRE) && !begin_type && trig_hit && !wr_ctrl
        |=> state_ff == RUN_IDLE)
        else $error("end trace did not end at trigger");
    AST_ARM_CLEARS: assert property (arm_start |=> (fifo_count_ff == 4'h0) && (state_ff == RUN_PRE) &&
        !a_flag_ff && !b_flag_ff)
        else $error("arming did not clear status");
    AST_BEGIN_NOT_FULL: assert property ((state_ff == RUN_POST) |-> fifo_count_ff < FIFO_FULL)
        else $error("begin trace still running with full fifo");
    AST_STOP_NOW: assert property (stop |=> (state_ff == RUN_IDLE) ##1 (state_ff == RUN_IDLE) || arm_start)
        else $error("manual stop did not end the run");
    AST_EVENT_LOW_BYTE: assert property (push && ev_only |-> push_data[15:8] == 8'h00 &&
        push_data[7:0] == cpu_i.data)
        else $error("event mode entry not in low byte");
    AST_EVENT_BEGIN: assert property ((state_ff == RUN_PRE) && ev_only && trig_hit && !wr_ctrl
        |=> state_ff == RUN_POST)
        else $error("event mode run not begin type");
    AST_RW_QUAL: assert property (qa && debug_control_reg_ff.rw_qualify_enable_a
        |-> cpu_i.rw == debug_control_reg_ff.rw_match_value_a)
        else $error("read/write qualification ignored");
    AST_BRK_NEEDS_EN: assert property (brk_tag_o |-> $past(debug_control_reg_ff.break_request_enable) &&
        $past(debug_control_reg_ff.tag_select) && $past(armed))
        else $error("tag break without break enable");
    AST_ARMED_FLAG_DROP: assert property (armed && (nxt_state == RUN_IDLE) |=> !armed ##0 irq_sts_ff[IRQ_RUN_END])
        else $error("armed flag survived end of run");

endmodule
`default_nettype wire

// ===== verification/dbgtb_cpu_model.sv
// behavioural cpu bus and instruction queue driving the debug block
`default_nettype none
module dbgtb_cpu_model
    import dbgtb_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // bus and queue view
    output var  dbgtb_cpu_s cpu_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cpu_o = '0;

    // one bus cycle; opcode fetches are always reads, so no rw qualify is needed
    task automatic put(input logic [15:0] a, input logic v, input logic f, input logic e, input logic c);
        @(posedge clk_i);
        cpu_o <= {a, a[7:0], v, 1'b1, f, e, 1'b0, c, a};
        @(posedge clk_i);
        // released bus shows inverted address and data with valid and the other control lines low, so a stale address never matches
        cpu_o <= {~a, ~a[7:0], 6'h00, ~a};
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the debug trigger and breakpoint block
`default_nettype none
module tb
    import dbgtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i, rst_i, cyc, stb, we, ack, brk_tag, brk_force, bg, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o;
    dbgtb_cpu_s  cpu;
    int          error_cnt = 0;
    int          checked = 0;

    dbgtb_cpu_model i_cpu (.clk_i(clk_i), .cpu_o(cpu));
    dbgtb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_i(cpu),
        .brk_tag_o(brk_tag), .brk_force_o(brk_force), .background_entry_o(bg), .irq_o(irq));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
        // no local limit: only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask

    // one cpu cycle, then the break outputs in the following cycle
    task automatic see(input logic [15:0] a, input logic v, input logic f, input logic e, input logic [2:0] exp);
        i_cpu.put(a, v, f, e, 1'b0);
        @(posedge clk_i);
        chk("brk_tag_force_bg", {29'h0, exp}, {29'h0, brk_tag, brk_force, bg});
    endtask

    task automatic s_regs();
        rd("ctrl", OFS_CTRL, 32'h0);
        rd("stat", OFS_STAT, 32'h0);
        wr(OFS_CMPA, 32'h1234);
        rd("cmpa", OFS_CMPA, 32'h1234);
        rd("unmapped", 8'h20, 32'h0);
        wr(OFS_IRQ_MSK, 32'h7);
    endtask

    task automatic s_end_run();
        wr(OFS_TRIG, {28'h0, MODE_A_ONLY});
        wr(OFS_CTRL, 32'hc0);
        rd("stat_armed", OFS_STAT, 32'h80);
        i_cpu.put(16'h0500, 1'b1, 1'b0, 1'b0, 1'b1);
        i_cpu.put(16'h1234, 1'b1, 1'b0, 1'b0, 1'b0);
        rd("stat_end", OFS_STAT, 32'h41);
        chk("irq", 32'h1, {31'h0, irq});
        rd("fifo", OFS_FIFO, 32'h0500);
        wr(OFS_IRQ_STS, 32'h7);
        rd("irq_sts", OFS_IRQ_STS, 32'h0);
        chk("irq_clr", 32'h0, {31'h0, irq});
    endtask

    task automatic s_stop();
        wr(OFS_CTRL, 32'hc0);
        rd("stat_rearm", OFS_STAT, 32'h80);
        wr(OFS_CTRL, 32'h80);
        rd("stat_stop", OFS_STAT, 32'h0);
    endtask

    task automatic s_break();
        wr(OFS_TRIG, 32'h09);
        wr(OFS_CTRL, 32'hc0);
        see(16'h1234, 1'b1, 1'b1, 1'b0, 3'b000);
        wr(OFS_CTRL, 32'hd0);
        see(16'h1234, 1'b1, 1'b0, 1'b0, 3'b000);
        see(16'h0000, 1'b0, 1'b0, 1'b1, 3'b010);
        wr(OFS_CTRL, 32'hf0);
        see(16'h1234, 1'b1, 1'b1, 1'b0, 3'b100);
        see(16'h0000, 1'b0, 1'b0, 1'b1, 3'b001);
    endtask

    task automatic s_event();
        wr(OFS_CMPB, 32'h0042);
        wr(OFS_TRIG, 32'h83);
        // b qualified on writes only; the model only ever reads
        wr(OFS_CTRL, 32'hc1);
        i_cpu.put(16'h0042, 1'b1, 1'b1, 1'b0, 1'b0);
        i_cpu.put(16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
        rd("stat_rw", OFS_STAT, 32'h80);
        wr(OFS_CTRL, 32'hc3);
        i_cpu.put(16'h0042, 1'b1, 1'b1, 1'b0, 1'b0);
        rd("stat_fetch", OFS_STAT, 32'h80);
        i_cpu.put(16'h0077, 1'b1, 1'b0, 1'b1, 1'b0);
        rd("stat_begin", OFS_STAT, 32'ha1);
        wr(OFS_CTRL, 32'h00);
        rd("fifo_evt", OFS_FIFO, 32'h0077);
    endtask

    task automatic wrap_up();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // the whole sequence takes about 120 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        wrap_up();
    end

    initial begin
        {cyc, stb, we, adr, sel, dat} = '0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_end_run();
        s_stop();
        s_break();
        s_event();
        wrap_up();
    end
endmodule
`default_nettype wire
